// >>> icslp_pkg.sv
// Constants, register map and types of the internal clock settling block.
// Assumes a 125 MHz system clock and an APB master with 32-bit data.
// How it works
// - Coarse steps above 15 percent, eight per octave
// - Each further octave takes twice as long
// - Medium steps between 15 and 5 percent
// - At most eight medium steps reach 5 percent
// - Stable flag set once error below 5 percent
// - Minimum steps below 5 percent, 24 at most
// - 32 corrections 15 percent to minimum error
// - Capacitor 384 fixed units plus trim units
// - Trim resets to 128, capacitor 512 units
// - Each trim unit shifts base frequency 0.195 percent
// - Generator runs and wakes CPU in wait
// - Stop without keep option halts all clocks low
// - Stop with keep option runs, no wakeup
// - Stop without keep clears both stable flags
// - Stop without keep clears monitor, enable, flag
// - Stop without keep keeps select, clock enables, factor, trim, code
// - Settling restarts on reset, factor or trim write, re-enable
// - First medium correction keeps coarse spacing, later ones four base periods
// - Generated clock is factor times base clock
package icslp_pkg;

    // Timing
    localparam int CLK_FREQ_HZ  = 125_000_000;
    localparam int BASE_FREQ_HZ = 307_200;
    localparam int BASE_CYC     = CLK_FREQ_HZ / BASE_FREQ_HZ;
    localparam int CAP_FIXED    = 384;
    localparam int CAP_NOMINAL  = 512;
    localparam int CAP_SHIFT    = 9;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_MULT  = 8'h04;
    localparam logic [7:0] OFS_TRIM  = 8'h08;
    localparam logic [7:0] OFS_DIV   = 8'h0c;
    localparam logic [7:0] OFS_STAGE = 8'h10;

    // Control register field positions
    localparam int BIT_INT_EN   = 0;
    localparam int BIT_EXT_EN   = 1;
    localparam int BIT_CLK_SEL  = 2;
    localparam int BIT_MON_ON   = 3;
    localparam int BIT_IRQ_EN   = 4;
    localparam int BIT_FAULT    = 5;

    // Reset values
    localparam logic [6:0]  MULT_RST = 7'h15;
    localparam logic [7:0]  TRIM_RST = 8'h80;
    localparam logic [11:0] CODE_RST = 12'h000;

    // Loop filter code {divider, stage}; divider saturates at 9
    localparam logic [11:0] CODE_MAX    = 12'h9ff;
    localparam logic [12:0] STEP_COARSE = 13'h0020;
    localparam logic [12:0] STEP_MEDIUM = 13'h0008;
    localparam logic [12:0] STEP_FINE   = 13'h0001;
    localparam logic [12:0] BAND_FINE   = 13'h0018;
    localparam logic [12:0] BAND_MEDIUM = 13'h0058;
    localparam logic [2:0]  COARSE_PER_OCT = 3'h7;
    localparam logic [3:0]  OCT_MAX     = 4'h9;
    localparam logic [11:0] TICKS_PER_CORR = 12'h004;

    typedef enum logic [1:0]
    {
        LF_OFF    = 2'b00,
        LF_COARSE = 2'b01,
        LF_MEDIUM = 2'b11,
        LF_FINE   = 2'b10
    } icslp_phase_type;

    typedef struct packed
    {
        logic ext_stable;
        logic int_stable;
        logic fault;
        logic irq_en;
        logic mon_on;
        logic clk_sel;
        logic ext_en;
        logic int_en;
    } icslp_ctrl_type;

    localparam icslp_ctrl_type CTRL_RST = '{int_en: 1'b1, default: 1'b0};

endpackage : icslp_pkg

// >>> icslp_base_tick.sv
// Low frequency base clock model: period follows capacitor size.
// Assumes trim comes from a register on the same clock.
`timescale 1ns/1ps
module icslp_base_tick
    import icslp_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // Control
    input  wire logic       i_run,
    input  wire logic [7:0] i_trim,
    // Base clock
    output logic            o_tick,
    output logic            o_level
);

    logic [19:0] half_cyc;
    logic [19:0] cnt_r;
    logic [19:0] cnt_nxt;
    logic        level_r;
    logic        level_nxt;
    logic        tick_r;
    logic        tick_nxt;

    // Period scales with fixed plus trimmed units
    always_comb
    begin
        half_cyc = 20'((20'(BASE_CYC) * (20'(CAP_FIXED) + 20'(i_trim)))
                   >> (CAP_SHIFT + 1));
        cnt_nxt   = cnt_r + 20'h00001;
        level_nxt = level_r;
        tick_nxt  = 1'b0;
        if (!i_run)
        begin
            cnt_nxt   = 20'h00000;
            level_nxt = 1'b0;
        end
        else if (cnt_r + 20'h00001 >= half_cyc)
        begin
            cnt_nxt   = 20'h00000;
            level_nxt = !level_r;
            tick_nxt  = level_r;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            cnt_r   <= 20'h00000;
            level_r <= 1'b0;
            tick_r  <= 1'b0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            level_r <= level_nxt;
            tick_r  <= tick_nxt;
        end
    end

    assign o_tick  = tick_r;
    assign o_level = level_r;

endmodule : icslp_base_tick

// >>> icslp_top.sv
// Internal clock generator settling, trim and low power control.
// Assumes stop, wait and option inputs come from logic on I_CLK.
`timescale 1ns/1ps
module icslp_top
    import icslp_pkg::*;
(
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_NRST,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Low power and options
    input  wire logic        I_STOP,
    input  wire logic        I_WAIT,
    input  wire logic        I_KEEP_CLK,
    // Monitor and external oscillator events
    input  wire logic        I_MON_FAULT,
    input  wire logic        I_EXT_STABLE_SET,
    // Clock outputs and status
    output logic             O_BASE_CLK,
    output logic             O_CLK_GATE,
    output logic             O_GEN_RUN,
    output logic             O_INT_STABLE,
    output logic             O_EXT_STABLE,
    output logic             O_MON_ON,
    output logic             O_IRQ,
    output logic             O_WAKE,
    output logic [3:0]       O_DIV_SEL,
    output logic [7:0]       O_STAGE_SEL
);

    icslp_ctrl_type  ctrl_r;
    icslp_ctrl_type  ctrl_nxt;
    logic [6:0]      mult_r;
    logic [6:0]      mult_nxt;
    logic [7:0]      trim_r;
    logic [7:0]      trim_nxt;
    logic [31:0]     rdata_r;
    logic [31:0]     rdata_nxt;
    logic            err_r;
    logic            err_nxt;
    icslp_phase_type phase_r;
    icslp_phase_type phase_nxt;
    logic [11:0]     code_r;
    logic [11:0]     code_nxt;
    logic [11:0]     ticks_r;
    logic [11:0]     ticks_nxt;
    logic [2:0]      coarse_r;
    logic [2:0]      coarse_nxt;
    logic [3:0]      oct_r;
    logic [3:0]      oct_nxt;
    logic            restart_r;
    logic            restart_nxt;
    logic            base_tick;
    logic            base_level;
    logic            halt;
    logic            gen_run;
    logic            setup;
    logic            wr;
    logic            rd;
    logic            hit;
    logic [11:0]     target;
    logic [12:0]     diff;
    logic [12:0]     err_abs;
    logic [12:0]     step;
    logic [12:0]     moved;
    logic [11:0]     interval;

    // Code whose period gives factor times base clock
    function automatic logic [11:0] target_code(input logic [6:0] n);
        logic [2:0] msb;
        logic [7:0] mant;
        msb  = 3'h0;
        mant = 8'h00;
        for (int i = 0; i < 7; i++)
        begin
            if (n[i])
            begin
                msb = 3'(i);
            end
        end
        mant = 8'({n, 8'h00} >> msb);
        return CODE_MAX - {1'b0, msb, ~mant} - 12'h100;
    endfunction : target_code

    function automatic logic [12:0] abs13(input logic [12:0] v);
        return v[12] ? 13'(-v) : v;
    endfunction : abs13

    function automatic logic in_fine(input logic [12:0] v);
        return abs13(v) <= BAND_FINE;
    endfunction : in_fine

    assign halt    = I_STOP && !I_KEEP_CLK;
    assign gen_run = ctrl_r.int_en && !halt;

    icslp_base_tick u_base
    (
        .i_clk   (I_CLK),
        .i_nrst  (I_NRST),
        .i_run   (gen_run),
        .i_trim  (trim_r),
        .o_tick  (base_tick),
        .o_level (base_level)
    );

    // APB decode
    assign setup = I_PSEL && !I_PENABLE;
    assign wr    = I_PSEL && I_PENABLE && I_PWRITE;
    assign rd    = setup && !I_PWRITE;
    assign hit   = (I_PADDR == OFS_CTRL) || (I_PADDR == OFS_MULT)
                || (I_PADDR == OFS_TRIM) || (I_PADDR == OFS_DIV)
                || (I_PADDR == OFS_STAGE);

    // Registers and bit interaction
    always_comb
    begin
        ctrl_nxt    = ctrl_r;
        mult_nxt    = mult_r;
        trim_nxt    = trim_r;
        rdata_nxt   = rdata_r;
        err_nxt     = 1'b0;
        restart_nxt = 1'b0;
        if (setup)
        begin
            err_nxt = !hit;
        end
        if (rd)
        begin
            if (I_PADDR == OFS_CTRL)
            begin
                rdata_nxt = {24'h000000, ctrl_r};
            end
            else if (I_PADDR == OFS_MULT)
            begin
                rdata_nxt = {25'h0000000, mult_r};
            end
            else if (I_PADDR == OFS_TRIM)
            begin
                rdata_nxt = {24'h000000, trim_r};
            end
            else if (I_PADDR == OFS_DIV)
            begin
                rdata_nxt = {28'h0000000, code_r[11:8]};
            end
            else if (I_PADDR == OFS_STAGE)
            begin
                rdata_nxt = {24'h000000, code_r[7:0]};
            end
            else
            begin
                rdata_nxt = 32'h00000000;
            end
        end
        if (wr && (I_PADDR == OFS_CTRL))
        begin
            ctrl_nxt.int_en  = I_PWDATA[BIT_INT_EN];
            ctrl_nxt.ext_en  = I_PWDATA[BIT_EXT_EN];
            ctrl_nxt.clk_sel = I_PWDATA[BIT_CLK_SEL];
            ctrl_nxt.mon_on  = I_PWDATA[BIT_MON_ON]
                && (ctrl_r.int_stable || ctrl_r.mon_on);
            ctrl_nxt.irq_en  = I_PWDATA[BIT_IRQ_EN];
            if (I_PWDATA[BIT_FAULT])
            begin
                ctrl_nxt.fault = 1'b0;
            end
            if (I_PWDATA[BIT_INT_EN] && !ctrl_r.int_en)
            begin
                restart_nxt = 1'b1;
            end
        end
        if (wr && (I_PADDR == OFS_MULT))
        begin
            mult_nxt        = I_PWDATA[6:0];
            ctrl_nxt.mon_on = 1'b0;
            restart_nxt     = 1'b1;
        end
        if (wr && (I_PADDR == OFS_TRIM))
        begin
            trim_nxt        = I_PWDATA[7:0];
            ctrl_nxt.mon_on = 1'b0;
            restart_nxt     = 1'b1;
        end
        // Fault event wins over a clear in the same cycle
        if (I_MON_FAULT && ctrl_r.mon_on)
        begin
            ctrl_nxt.fault = 1'b1;
        end
        if (I_EXT_STABLE_SET && ctrl_r.ext_en)
        begin
            ctrl_nxt.ext_stable = 1'b1;
        end
        if (!ctrl_nxt.mon_on)
        begin
            ctrl_nxt.irq_en = 1'b0;
            ctrl_nxt.fault  = 1'b0;
        end
        if (!ctrl_nxt.ext_en)
        begin
            ctrl_nxt.ext_stable = 1'b0;
        end
        // Halting stop leaves select, clock enables, factor, trim, code
        if (halt)
        begin
            ctrl_nxt.int_stable = 1'b0;
            ctrl_nxt.ext_stable = 1'b0;
            ctrl_nxt.mon_on     = 1'b0;
            ctrl_nxt.irq_en     = 1'b0;
            ctrl_nxt.fault      = 1'b0;
        end
        // Stable flag follows the loop filter
        if (!gen_run || restart_r || phase_r == LF_OFF)
        begin
            ctrl_nxt.int_stable = 1'b0;
        end
        else if (base_tick && (ticks_r + 12'h001 >= interval)
                 && in_fine(13'({1'b0, target}) - 13'({1'b0, code_nxt})))
        begin
            ctrl_nxt.int_stable = 1'b1;
        end
    end

    // Loop filter
    always_comb
    begin
        target   = target_code(mult_r);
        diff     = 13'({1'b0, target}) - 13'({1'b0, code_r});
        err_abs  = abs13(diff);
        interval = (phase_r == LF_COARSE)
                 ? 12'(TICKS_PER_CORR << oct_r)
                 : TICKS_PER_CORR;
        if (err_abs > BAND_MEDIUM)
        begin
            step = STEP_COARSE;
        end
        else if (err_abs > BAND_FINE)
        begin
            step = STEP_MEDIUM;
        end
        else
        begin
            step = (err_abs == 13'h0000) ? 13'h0000 : STEP_FINE;
        end
        moved = diff[12] ? 13'({1'b0, code_r}) - step
                         : 13'({1'b0, code_r}) + step;
        phase_nxt  = phase_r;
        code_nxt   = code_r;
        ticks_nxt  = ticks_r;
        coarse_nxt = coarse_r;
        oct_nxt    = oct_r;
        case (phase_r)
            LF_OFF:
            begin
                ticks_nxt  = 12'h000;
                coarse_nxt = 3'h0;
                oct_nxt    = 4'h0;
                if (gen_run)
                begin
                    phase_nxt = LF_COARSE;
                end
            end
            default:
            begin
                if (base_tick)
                begin
                    ticks_nxt = ticks_r + 12'h001;
                    if (ticks_r + 12'h001 >= interval)
                    begin
                        ticks_nxt = 12'h000;
                        code_nxt  = moved[12] ? 12'h000
                                  : (moved[11:0] > CODE_MAX) ? CODE_MAX
                                  : moved[11:0];
                        if (phase_r == LF_COARSE)
                        begin
                            coarse_nxt = coarse_r + 3'h1;
                            if (coarse_r == COARSE_PER_OCT
                                && oct_r != OCT_MAX)
                            begin
                                oct_nxt = oct_r + 4'h1;
                            end
                        end
                        if (err_abs <= BAND_FINE)
                        begin
                            phase_nxt = LF_FINE;
                        end
                        else if (err_abs <= BAND_MEDIUM)
                        begin
                            phase_nxt = LF_MEDIUM;
                        end
                    end
                end
            end
        endcase
        if (!gen_run || restart_r)
        begin
            phase_nxt = LF_OFF;
            code_nxt  = code_r;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            ctrl_r    <= CTRL_RST;
            mult_r    <= MULT_RST;
            trim_r    <= TRIM_RST;
            rdata_r   <= 32'h00000000;
            err_r     <= 1'b0;
            restart_r <= 1'b0;
            phase_r   <= LF_OFF;
            code_r    <= CODE_RST;
            ticks_r   <= 12'h000;
            coarse_r  <= 3'h0;
            oct_r     <= 4'h0;
        end
        else
        begin
            ctrl_r    <= ctrl_nxt;
            mult_r    <= mult_nxt;
            trim_r    <= trim_nxt;
            rdata_r   <= rdata_nxt;
            err_r     <= err_nxt;
            restart_r <= restart_nxt;
            phase_r   <= phase_nxt;
            code_r    <= code_nxt;
            ticks_r   <= ticks_nxt;
            coarse_r  <= coarse_nxt;
            oct_r     <= oct_nxt;
        end
    end

    // Outputs
    assign O_PRDATA     = rdata_r;
    assign O_PREADY     = 1'b1;
    assign O_PSLVERR    = err_r && I_PSEL && I_PENABLE;
    assign O_BASE_CLK   = base_level;
    assign O_CLK_GATE   = !halt;
    assign O_GEN_RUN    = gen_run;
    assign O_INT_STABLE = ctrl_r.int_stable;
    assign O_EXT_STABLE = ctrl_r.ext_stable;
    assign O_MON_ON     = ctrl_r.mon_on;
    assign O_IRQ        = ctrl_r.fault && ctrl_r.irq_en;
    assign O_WAKE       = O_IRQ && I_WAIT && !I_STOP;
    assign O_DIV_SEL    = code_r[11:8];
    assign O_STAGE_SEL  = code_r[7:0];

endmodule : icslp_top

// >>> icslp_props.sv
// Checker of the clock settling block, watching top ports only.
// Bound into every icslp_top instance; one clock, sync low reset.
`timescale 1ns/1ps
module icslp_props
    import icslp_pkg::*;
(
    input wire logic        I_CLK,
    input wire logic        I_NRST,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [7:0]  I_PADDR,
    input wire logic        I_STOP,
    input wire logic        I_WAIT,
    input wire logic        I_KEEP_CLK,
    input wire logic        O_BASE_CLK,
    input wire logic        O_CLK_GATE,
    input wire logic        O_GEN_RUN,
    input wire logic        O_INT_STABLE,
    input wire logic        O_EXT_STABLE,
    input wire logic        O_MON_ON,
    input wire logic        O_IRQ,
    input wire logic        O_WAKE,
    input wire logic [3:0]  O_DIV_SEL,
    input wire logic [7:0]  O_STAGE_SEL
);
    logic [11:0] code_r;
    logic [11:0] code_nxt;
    logic [11:0] gap_r;
    logic [11:0] gap_nxt;

    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);

    // Cycles since the loop filter code last moved
    always_comb
    begin
        code_nxt = {O_DIV_SEL, O_STAGE_SEL};
        gap_nxt  = (code_nxt != code_r) ? 12'h000 :
                   (gap_r == 12'hfff) ? gap_r : gap_r + 12'h001;
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            code_r <= 12'h000;
            gap_r  <= 12'hfff;
        end
        else
        begin
            code_r <= code_nxt;
            gap_r  <= gap_nxt;
        end
    end

    sequence s_cold_stop;
        I_STOP && !I_KEEP_CLK;
    endsequence

    sequence s_mult_wr;
        I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == OFS_MULT;
    endsequence

    gate_low_a: assert property (s_cold_stop |-> !O_CLK_GATE && !O_GEN_RUN)
        else $error("clock gate open in stop without keep");
    cold_clear_a: assert property (s_cold_stop |=>
        !O_INT_STABLE && !O_EXT_STABLE && !O_MON_ON)
        else $error("flags not cleared by stop");
    cold_keep_a: assert property (s_cold_stop |=>
        $stable({O_DIV_SEL, O_STAGE_SEL}))
        else $error("loop code moved in stop");
    base_low_a: assert property (s_cold_stop ##1 s_cold_stop |-> !O_BASE_CLK)
        else $error("base clock runs in stop");
    keep_run_a: assert property (I_STOP && I_KEEP_CLK |-> O_CLK_GATE && !O_WAKE)
        else $error("keep option stop misbehaves");
    wait_wake_a: assert property (O_WAKE == (O_IRQ && I_WAIT && !I_STOP))
        else $error("wake output wrong");
    irq_mon_a: assert property (O_IRQ |-> O_MON_ON)
        else $error("irq while monitor off");
    mon_guard_a: assert property ($rose(O_MON_ON) |-> $past(O_INT_STABLE))
        else $error("monitor on before stable");
    mult_restart_a: assert property (s_mult_wr |-> ##[1:2] !O_INT_STABLE)
        else $error("stable kept after factor write");
    corr_gap_a: assert property (code_nxt != code_r |-> gap_r >= 12'h4b0)
        else $error("corrections too close");
endmodule : icslp_props

bind icslp_top icslp_props i_icslp_props (.*);

// >>> tb.sv
// Self-checking bench of the clock settling block over APB.
// Assumes APB slave with at most 15 wait states and a 125 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb
    import icslp_pkg::*;
;
    typedef struct packed
    {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic        e;
    } icslp_row_type;

    logic I_CLK = 0, I_NRST = 0, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0;
    logic [7:0] I_PADDR = 8'h00;
    logic [31:0] I_PWDATA = 32'h0, O_PRDATA, rd;
    logic I_STOP = 0, I_WAIT = 0, I_KEEP_CLK = 0, I_MON_FAULT = 0;
    logic I_EXT_STABLE_SET = 0, O_PREADY, O_PSLVERR, er;
    logic O_BASE_CLK, O_CLK_GATE, O_GEN_RUN, O_INT_STABLE, O_EXT_STABLE;
    logic O_MON_ON, O_IRQ, O_WAKE;
    logic [3:0] O_DIV_SEL;
    logic [7:0] O_STAGE_SEL, t;
    logic [11:0] code, d;
    int errors = 0, tests_run = 0, n, p, nc;
    icslp_row_type rows [8] = '{
        '{0, OFS_CTRL, 0, 32'h01, 0},
        '{0, OFS_MULT, 0, 32'h15, 0},
        '{0, OFS_TRIM, 0, 32'h80, 0},
        '{1, OFS_DIV, 32'h5, 0, 0},
        '{0, OFS_DIV, 0, 32'h00, 0},
        '{1, OFS_CTRL, 32'h09, 0, 0},
        '{0, OFS_CTRL, 0, 32'h01, 0},
        '{1, 8'h14, 32'hff, 0, 1}};

    always #4 I_CLK = ~I_CLK;

    icslp_top i_icslp_top (.*);

    task test_done;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge I_CLK);
        I_PSEL <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE <= w;
        I_PADDR <= a;
        I_PWDATA <= wd;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge I_CLK);
            if (O_PREADY === 1'b1) break;
        end
        if (k == 16) begin errors++; test_done(); end
        rd = O_PRDATA;
        er = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask : apb

    // Cycles until the loop filter code moves
    task wait_code(output int c);
        logic [11:0] s;
        s = {O_DIV_SEL, O_STAGE_SEL};
        for (c = 1; c < 20000; c++)
        begin
            @(posedge I_CLK);
            #1;
            if ({O_DIV_SEL, O_STAGE_SEL} !== s) break;
        end
        if (c == 20000) begin errors++; test_done(); end
    endtask : wait_code

    // Cycles from one rising base clock edge to the next
    task period(output int c);
        int k;
        c = 0;
        for (k = 0; k < 3000 && O_BASE_CLK !== 1'b0; k++) @(posedge I_CLK);
        for (; k < 3000 && O_BASE_CLK !== 1'b1; k++) @(posedge I_CLK);
        for (; k < 3000 && O_BASE_CLK === 1'b1; k++, c++) @(posedge I_CLK);
        for (; k < 3000 && O_BASE_CLK !== 1'b1; k++, c++) @(posedge I_CLK);
        if (k >= 3000) begin errors++; test_done(); end
    endtask : period

    task pulse_ext;
        @(posedge I_CLK);
        I_EXT_STABLE_SET <= 1'b1;
        @(posedge I_CLK);
        I_EXT_STABLE_SET <= 1'b0;
    endtask : pulse_ext

    initial
    begin
        repeat (3) @(posedge I_CLK);
        I_NRST <= 1'b1;
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) `CHK(rd, rows[i].q)
            `CHK(er, rows[i].e)
        end
        $display("register rows done");
        // Step size and spacing while settling from reset
        code = {O_DIV_SEL, O_STAGE_SEL};
        wait_code(p);
        nc = 0;
        for (n = 1; n <= 9; n++)
        begin
            d = {O_DIV_SEL, O_STAGE_SEL} - code;
            if (d[11]) d = -d;
            `CHK(d == 12'h020 || d == 12'h008 || d == 12'h001, 1'b1)
            if (d == 12'h020) `CHK(O_INT_STABLE, 1'b0)
            if (d == 12'h020) nc++;
            if (n > 1) `CHK((p + 203) / 406, (n == 9 && nc == 9) ? 8 : 4)
            code = {O_DIV_SEL, O_STAGE_SEL};
            if (n < 9) wait_code(p);
        end
        $display("settling steps done");
        foreach (rows[i])
        begin
            t = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'h80;
            if (i < 3)
            begin
                apb(1'b1, OFS_TRIM, {24'h0, t});
                apb(1'b0, OFS_TRIM, 32'h0);
                `CHK(rd, {24'h0, t})
                period(p);
                period(p);
                `CHK(p, 2 * ((BASE_CYC * (CAP_FIXED + t)) >> 10))
            end
        end
        apb(1'b1, OFS_MULT, 32'h15);
        $display("trim periods done");
        apb(1'b1, OFS_CTRL, 32'h19);
        @(posedge I_CLK);
        I_MON_FAULT <= 1'b1;
        @(posedge I_CLK);
        I_MON_FAULT <= 1'b0;
        #1 `CHK(O_IRQ, 1'b0)
        apb(1'b1, OFS_CTRL, 32'h03);
        pulse_ext();
        apb(1'b1, OFS_CTRL, 32'h07);
        #1 `CHK(O_EXT_STABLE, 1'b1)
        @(posedge I_CLK);
        I_STOP <= 1'b1;
        I_WAIT <= 1'b1;
        @(posedge I_CLK);
        #1 `CHK({O_CLK_GATE, O_GEN_RUN, O_WAKE}, 3'h0)
        code = {O_DIV_SEL, O_STAGE_SEL};
        repeat (600) @(posedge I_CLK);
        #1 `CHK({O_BASE_CLK, O_EXT_STABLE, O_INT_STABLE, O_MON_ON}, 4'h0)
        `CHK({O_DIV_SEL, O_STAGE_SEL}, code)
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(rd, 32'h07)
        apb(1'b0, OFS_TRIM, 32'h0);
        `CHK(rd, 32'h80)
        apb(1'b0, OFS_MULT, 32'h0);
        `CHK(rd, 32'h15)
        I_STOP <= 1'b0;
        $display("cold stop done");
        pulse_ext();
        `CHK({O_GEN_RUN, O_WAKE}, 2'h2)
        I_STOP <= 1'b1;
        I_KEEP_CLK <= 1'b1;
        period(p);
        period(p);
        `CHK(p, 406)
        #1 `CHK({O_CLK_GATE, O_GEN_RUN, O_EXT_STABLE, O_WAKE}, 4'he)
        $display("keep stop done");
        // Reset in mid run restarts settling from the reset code
        @(posedge I_CLK);
        I_STOP <= 1'b0;
        I_NRST <= 1'b0;
        repeat (3) @(posedge I_CLK);
        I_NRST <= 1'b1;
        #1 `CHK({O_DIV_SEL, O_STAGE_SEL}, CODE_RST)
        `CHK({O_INT_STABLE, O_EXT_STABLE}, 2'h0)
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(rd, {24'h0, CTRL_RST})
        apb(1'b0, OFS_TRIM, 32'h0);
        `CHK(rd, {24'h0, TRIM_RST})
        $display("mid run reset done");
        test_done();
    end
endmodule : tb
